//--- rtl/embi_pkg.sv
// Shared constants and types of the external memory bus interface
package embi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;  // Address bus lines
  localparam int DATA_W = 16;  // Data bus lines
  localparam int SYNC_W = 6 + ADDR_W + DATA_W;  // Synchronised pin bits

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;  // Address lines
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;  // Data lines
  localparam logic              IDLE_HI  = 1'h1;      // Strobes idle high

  // Address space of an external access
  typedef enum logic [1:0] {
    EMBI_SP_DATA = 2'b00,
    EMBI_SP_PROG = 2'b01,
    EMBI_SP_IO   = 2'b10
  } embi_space_t;

  // Bus sequencer states
  typedef enum logic [1:0] {
    EMBI_S_IDLE = 2'b00,
    EMBI_S_ACC  = 2'b01,
    EMBI_S_HOLD = 2'b10
  } embi_state_t;

  // One access request from the core
  typedef struct packed {
    embi_space_t       space;   // Target space
    logic              write;   // High for a write
    logic              global;  // Global data space access
    logic              fetch;   // Instruction fetch
    logic [ADDR_W-1:0] addr;    // Word address
    logic [DATA_W-1:0] wdata;   // Write data
  } embi_req_t;

endpackage

//--- rtl/embi_bus.sv
// External memory bus interface: sequencer, hold and DMA slave
//
// Notes on behaviour
// - One address bus serves data, program, I/O
// - Address lines float in hold or float-all
// - Granted hold plus external request: address inputs
// - Data floats unless driving, reset, hold, float-all
// - Data bus also carries DMA transfer words
// - Space selects high unless used; float when held
// - Ready low: wait a cycle, sample again
// - Ready high grants the global bus request
// - Read/write high by default, low writing
// - Strobe low only during external bus cycle
// - Read select low on every external read
// - Read select floats in hold or float-all
// - Hold request floats lines, grant goes low
// - Fetch indicator acknowledges DMA while granted
// - Write strobe falls as data is driven
// - Global request low on global data accesses
`timescale 1ns/100ps
`default_nettype none

module embi_bus
  import embi_pkg::*;
(
  input  wire logic              mclk,                     // 50 MHz clock
  input  wire logic              rst_n,                    // Sync reset
  input  wire logic              core_valid,               // Request valid
  input  wire embi_req_t         core_req,                 // Request
  output var  logic              core_ready,               // Can accept
  output var  logic              core_done,                // Access done
  output var  logic [DATA_W-1:0] core_rdata,               // Read data
  input  wire logic              hold_req_n,               // Hold pin
  input  wire logic              ready_pin,                // Ready pin
  input  wire logic              emul1_float_all_pin,      // Float-all pin
  output var  logic [ADDR_W-1:0] addr_o,                   // Address out
  output var  logic              addr_oe,                  // Address drive
  input  wire logic [ADDR_W-1:0] addr_i,                   // Address in
  output var  logic [DATA_W-1:0] data_o,                   // Data out
  output var  logic              data_oe,                  // Data drive
  input  wire logic [DATA_W-1:0] data_i,                   // Data in
  output var  logic              data_space_sel_n,         // Data space
  output var  logic              program_space_sel_n,      // Program space
  output var  logic              io_space_sel_n,           // I/O space
  output var  logic              ctl_oe,                   // Control drive
  output var  logic              rw_o,                     // Read/write out
  input  wire logic              rw_i,                     // Read/write in
  output var  logic              bus_cycle_strobe_n_o,     // Strobe out
  input  wire logic              bus_cycle_strobe_n_i,     // Strobe in
  output var  logic              read_sel_n,               // Read select
  output var  logic              write_strobe_n,           // Write strobe
  output var  logic              global_bus_request_n_o,   // Request out
  output var  logic              global_bus_request_n_oe,  // Request drive
  input  wire logic              global_bus_request_n_i,   // Request in
  output var  logic              bus_hold_grant_n,         // Hold grant
  output var  logic              bus_hold_grant_oe,        // Grant drive
  output var  logic              fetch_indicator_n,        // Fetch / ack
  output var  logic              fetch_indicator_oe,       // Fetch drive
  output var  logic              dma_valid,                // RAM access
  output var  logic              dma_write,                // RAM write
  output var  logic [ADDR_W-1:0] dma_addr,                 // RAM address
  output var  logic [DATA_W-1:0] dma_wdata,                // RAM wdata
  input  wire logic [DATA_W-1:0] dma_rdata                 // RAM rdata
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r;    // First stage, read by sync2_r only
  logic [SYNC_W-1:0] sync2_r;    // Second stage
  logic              hold_s;     // Hold request, active low
  logic              ready_s;    // Ready
  logic              float_s;    // Float-all, active low
  logic              br_s;       // External global request, low
  logic              bus_cycle_strobe_n_s;     // External strobe, low
  logic              rw_s;       // External read/write
  logic [ADDR_W-1:0] addr_s;     // External address
  logic [DATA_W-1:0] data_s;     // External data

  // Two flops on every pin; multi-bit buses are only read while the
  // far side keeps them steady under a low strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Idle pin levels, so no false hold or DMA request follows reset
      sync1_r <= {IDLE_HI, 1'b0, IDLE_HI, IDLE_HI, IDLE_HI, IDLE_HI,
                  ADDR_RST, DATA_RST};
      sync2_r <= {IDLE_HI, 1'b0, IDLE_HI, IDLE_HI, IDLE_HI, IDLE_HI,
                  ADDR_RST, DATA_RST};
    end else begin
      sync1_r <= {hold_req_n, ready_pin, emul1_float_all_pin,
                  global_bus_request_n_i, bus_cycle_strobe_n_i, rw_i,
                  addr_i, data_i};
      sync2_r <= sync1_r;
    end
  end

  assign {hold_s, ready_s, float_s, br_s, bus_cycle_strobe_n_s, rw_s,
          addr_s, data_s} = sync2_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  embi_state_t state_r;    // Current state
  embi_state_t state_nxt;  // Next state
  embi_req_t   cur_r;      // Access in progress
  logic        accept;     // Request taken this edge
  logic        finish;     // Access completes this edge
  logic        dma_sel;    // DMA into on-chip RAM requested
  logic        dma_rd;     // DMA read drives the data bus
  logic        bus_cycle_strobe_n_prev_r;  // Strobe one cycle earlier
  logic [1:0]  acc_age_r;    // Synchroniser latency since the take

  assign accept  = core_valid && core_ready;
  // Ready seen in the first two cycles was sampled before the strobe
  assign finish  = (state_r == EMBI_S_ACC) && ready_s &&
                   acc_age_r[1];
  assign dma_sel = (state_r == EMBI_S_HOLD) && !br_s;
  assign dma_rd  = dma_sel && !fetch_indicator_n && !bus_cycle_strobe_n_s && rw_s;

  // Next state: a pending core request wins over a hold request
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      EMBI_S_IDLE: begin
        if (accept) begin
          state_nxt = EMBI_S_ACC;
        end else if (!hold_s) begin
          state_nxt = EMBI_S_HOLD;
        end
      end
      EMBI_S_ACC: begin
        // Ready low keeps the cycle for one more sample
        if (finish) begin
          state_nxt = EMBI_S_IDLE;
        end
      end
      EMBI_S_HOLD: begin
        if (hold_s) begin
          state_nxt = EMBI_S_IDLE;
        end
      end
      default: state_nxt = EMBI_S_IDLE;
    endcase
  end

  // State, latched request and core handshake
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r    <= EMBI_S_IDLE;
      acc_age_r  <= 2'h0;
      cur_r      <= '0;
      core_ready <= 1'b0;
      core_done  <= 1'b0;
      core_rdata <= DATA_RST;
    end else begin
      state_r    <= state_nxt;
      core_ready <= (state_nxt == EMBI_S_IDLE);
      core_done  <= finish;
      // Age of the access, saturating once fresh samples arrive
      if (accept) begin
        acc_age_r <= 2'h0;
      end else if (state_r == EMBI_S_ACC) begin
        acc_age_r <= {acc_age_r[0], 1'b1};
      end
      // Latch the request when taken
      if (accept) begin
        cur_r <= core_req;
      end
      // Capture read data on completion
      if (finish && !cur_r.write) begin
        core_rdata <= data_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output enables
  // ----------------------------------------------------------------
  // Hold releases address, control and request lines; float-all releases every line; reset clears all enables
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_oe                  <= 1'b0;
      addr_oe                 <= 1'b0;
      data_oe                 <= 1'b0;
      global_bus_request_n_oe <= 1'b0;
      bus_hold_grant_oe       <= 1'b0;
      fetch_indicator_oe      <= 1'b0;
    end else begin
      ctl_oe  <= float_s && (state_nxt != EMBI_S_HOLD);
      addr_oe <= float_s && (state_nxt != EMBI_S_HOLD);
      // Driven only for a write cycle or a DMA read
      data_oe <= float_s && ((accept && core_req.write) ||
                 (state_r == EMBI_S_ACC && !finish && cur_r.write) ||
                 dma_rd);
      global_bus_request_n_oe <= float_s &&
                                 (state_nxt != EMBI_S_HOLD);
      bus_hold_grant_oe       <= float_s;
      fetch_indicator_oe      <= float_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle lines
  // ----------------------------------------------------------------
  // All lines change together at the start of a cycle; all but the address return to idle at the end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_o                 <= ADDR_RST;
      data_space_sel_n       <= IDLE_HI;
      program_space_sel_n    <= IDLE_HI;
      io_space_sel_n         <= IDLE_HI;
      rw_o                   <= IDLE_HI;
      bus_cycle_strobe_n_o   <= IDLE_HI;
      read_sel_n             <= IDLE_HI;
      write_strobe_n         <= IDLE_HI;
      global_bus_request_n_o <= IDLE_HI;
    end else if (accept) begin
      addr_o                 <= core_req.addr;
      data_space_sel_n       <= (core_req.space != EMBI_SP_DATA);
      program_space_sel_n    <= (core_req.space != EMBI_SP_PROG);
      io_space_sel_n         <= (core_req.space != EMBI_SP_IO);
      rw_o                   <= !core_req.write;
      bus_cycle_strobe_n_o   <= 1'b0;
      read_sel_n             <= core_req.write;
      write_strobe_n         <= !core_req.write;
      global_bus_request_n_o <= !(core_req.global &&
                                  core_req.space == EMBI_SP_DATA);
    end else if (finish) begin
      // Return to idle levels
      data_space_sel_n       <= IDLE_HI;
      program_space_sel_n    <= IDLE_HI;
      io_space_sel_n         <= IDLE_HI;
      rw_o                   <= IDLE_HI;
      bus_cycle_strobe_n_o   <= IDLE_HI;
      read_sel_n             <= IDLE_HI;
      write_strobe_n         <= IDLE_HI;
      global_bus_request_n_o <= IDLE_HI;
    end
  end

  // Write data, or on-chip RAM word during a DMA read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_o <= DATA_RST;
    end else if (accept) begin
      data_o <= core_req.wdata;
    end else if (dma_rd) begin
      data_o <= dma_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Hold grant and fetch indicator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_hold_grant_n  <= IDLE_HI;
      fetch_indicator_n <= IDLE_HI;
    end else begin
      bus_hold_grant_n <= (state_nxt != EMBI_S_HOLD);
      if (state_r == EMBI_S_HOLD) begin
        fetch_indicator_n <= !dma_sel;
      end else if (accept) begin
        fetch_indicator_n <= !core_req.fetch;
      end else if (finish || state_r == EMBI_S_IDLE) begin
        fetch_indicator_n <= IDLE_HI;
      end
    end
  end

  // ----------------------------------------------------------------
  // DMA slave into on-chip RAM
  // ----------------------------------------------------------------
  // Each falling external strobe under acknowledge is one access
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_cycle_strobe_n_prev_r <= IDLE_HI;
      dma_valid   <= 1'b0;
      dma_write   <= 1'b0;
      dma_addr    <= ADDR_RST;
      dma_wdata   <= DATA_RST;
    end else begin
      bus_cycle_strobe_n_prev_r <= bus_cycle_strobe_n_s;
      dma_valid   <= dma_sel && !fetch_indicator_n &&
                     !bus_cycle_strobe_n_s && bus_cycle_strobe_n_prev_r;
      dma_write   <= !rw_s;
      dma_addr    <= addr_s;
      dma_wdata   <= data_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  one_space_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $onehot0({!data_space_sel_n, !program_space_sel_n, !io_space_sel_n}))
    else $error("more than one space select low");

  addr_hold_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !bus_hold_grant_n |-> !addr_oe && !ctl_oe && !global_bus_request_n_oe)
    else $error("lines driven while hold granted");

  data_float_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !float_s |=> !data_oe && !ctl_oe && !bus_hold_grant_oe)
    else $error("line driven under float-all");

  strobe_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == EMBI_S_ACC) == !bus_cycle_strobe_n_o)
    else $error("strobe does not match bus cycle");

  ready_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == EMBI_S_ACC && !ready_s) |=>
      (state_r == EMBI_S_ACC) && !core_done)
    else $error("cycle ended with ready low");

  ready_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == EMBI_S_ACC && ready_s && acc_age_r[1]) |=>
      core_done && bus_cycle_strobe_n_o && global_bus_request_n_o)
    else $error("cycle not ended on ready");

  rw_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!rw_o == !write_strobe_n) && (rw_o || data_oe || !float_s ||
      $past(!float_s)))
    else $error("read/write and write strobe disagree");

  read_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && !core_req.write |=> !read_sel_n && rw_o)
    else $error("read select missing on read");

  global_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && core_req.global && core_req.space == EMBI_SP_DATA |=>
      !global_bus_request_n_o)
    else $error("global request missing");

  dma_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == EMBI_S_HOLD && !br_s) |=> !fetch_indicator_n)
    else $error("DMA request not acknowledged");

  hold_grant_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == EMBI_S_IDLE && !hold_s && !accept) |=>
      !bus_hold_grant_n && !read_sel_n == 1'b0)
    else $error("hold not granted");

endmodule

`default_nettype wire

//--- testbench/embi_ext_model.sv
// Partner model: external memory and DMA master on the bus pins
`timescale 1ns/100ps
`default_nettype none
module embi_ext_model
  import embi_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [3:0]        wait_cyc,       // Ready delay
  input  wire logic [ADDR_W-1:0] addr_o,
  input  wire logic              addr_oe,
  input  wire logic [DATA_W-1:0] data_o,
  input  wire logic              data_oe,
  input  wire logic              ctl_oe,
  input  wire logic              rw_o,
  input  wire logic              bus_cycle_strobe_n_o,
  input  wire logic              read_sel_n,
  input  wire logic              write_strobe_n,
  input  wire logic              global_bus_request_n_o,
  input  wire logic              global_bus_request_n_oe,
  output wire logic [ADDR_W-1:0] addr_i,
  output wire logic [DATA_W-1:0] data_i,
  output wire logic              rw_i,
  output wire logic              bus_cycle_strobe_n_i,
  output wire logic              global_bus_request_n_i,
  output wire logic              ready_pin
);
  logic [DATA_W-1:0] mem [16];  // Memory words
  logic [DATA_W-1:0] d_last;    // Last data wire level
  logic [3:0]        wcnt;      // Wait counter
  logic              rdy_r;     // Ready level
  logic [ADDR_W-1:0] m_addr;    // Master address
  logic [DATA_W-1:0] m_data;    // Master write data
  logic              m_den;     // Master drives data
  logic              m_rw;      // Master direction
  logic              m_bus_cycle_strobe_n;    // Master strobe
  logic              m_br;      // Master request, pulled up when idle

  // Idle master and preset memory
  initial begin
    m_addr = 16'h0000;
    m_data = 16'h0000;
    m_den = 1'b0;
    m_rw = 1'b1;
    m_bus_cycle_strobe_n = 1'b1;
    m_br = 1'b1;
    for (int i = 0; i < 16; i++) mem[i] = 16'hA500 ^ 16'(i);
  end

  // Wire levels; a released data bus shows the inverse of its last value
  assign data_i = data_oe ? data_o :
                  (ctl_oe && !read_sel_n) ? mem[addr_o[3:0]] :
                  m_den ? m_data : ~d_last;
  assign addr_i = addr_oe ? addr_o : (m_br ? ~m_addr : m_addr);
  assign rw_i = ctl_oe ? rw_o : m_rw;
  assign bus_cycle_strobe_n_i = ctl_oe ? bus_cycle_strobe_n_o : m_bus_cycle_strobe_n;
  assign global_bus_request_n_i = global_bus_request_n_oe ?
                                  global_bus_request_n_o : m_br;
  assign ready_pin = rdy_r;

  // Ready rises wait_cyc cycles into a strobe; write data latched
  always @(posedge mclk) begin
    d_last <= data_i;
    if (ctl_oe && !bus_cycle_strobe_n_o) begin
      wcnt <= wcnt + 4'h1;
      rdy_r <= (wcnt >= wait_cyc);
    end else begin
      wcnt <= 4'h0;
      rdy_r <= 1'b0;
    end
    if (data_oe && !write_strobe_n) mem[addr_o[3:0]] <= data_o;
  end

  // One DMA access: lines steady four clocks, then three clocks apart
  task automatic dma_access(input logic rd, input logic [15:0] a,
                            input logic [15:0] d);
    @(negedge mclk);
    m_addr = a;
    m_rw = rd;
    m_data = d;
    m_den = !rd;
    m_bus_cycle_strobe_n = 1'b0;
    repeat (4) @(negedge mclk);
    m_bus_cycle_strobe_n = 1'b1;
    repeat (3) @(negedge mclk);
    m_den = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/embi_bus_bench.sv
// Self-checking bench of the external memory bus interface
`timescale 1ns/100ps
`default_nettype none
module embi_bus_bench
  import embi_pkg::*;
;
  logic mclk, rst_n, core_valid, core_ready, core_done, hold_req_n;
  logic ready_pin, emul1_float_all_pin, addr_oe, data_oe, ctl_oe;
  logic data_space_sel_n, program_space_sel_n, io_space_sel_n, rw_o;
  logic rw_i, bus_cycle_strobe_n_o, bus_cycle_strobe_n_i, read_sel_n;
  logic write_strobe_n, global_bus_request_n_o, global_bus_request_n_oe;
  logic global_bus_request_n_i, bus_hold_grant_n, bus_hold_grant_oe;
  logic fetch_indicator_n, fetch_indicator_oe, dma_valid, dma_write;
  logic [ADDR_W-1:0] addr_o, addr_i, dma_addr;
  logic [DATA_W-1:0] core_rdata, data_o, data_i, dma_wdata, dma_rdata;
  logic [3:0]        wait_cyc;  // Ready delay of the memory
  embi_req_t         core_req;  // Core request
  int miscompares, total_checks, lat0, lat1, n;

  embi_bus       u_embi_bus (.*);
  embi_ext_model u_embi_ext_model (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // One core access, pins checked in its first cycle
  // ----------------------------------------------------------------
  task automatic access(input embi_space_t sp, input logic wr,
                        input logic gl, input logic fe,
                        input logic [15:0] a, output int lat);
    logic [15:0] d;
    d = a ^ 16'h5A5A;
    core_req = '{sp, wr, gl, fe, a, d};
    core_valid = 1'b1;
    n = 0;
    while (core_ready !== 1'b1 && n < 20) begin cyc(1); n++; end
    cyc(1);
    core_valid = 1'b0;
    chk_bit("dsel", sp != EMBI_SP_DATA, data_space_sel_n);
    chk_bit("psel", sp != EMBI_SP_PROG, program_space_sel_n);
    chk_bit("isel", sp != EMBI_SP_IO, io_space_sel_n);
    chk_word("addr", a, addr_o);
    chk_bit("rw", !wr, rw_o);
    chk_bit("rd sel", wr, read_sel_n);
    chk_bit("wr strobe", !wr, write_strobe_n);
    chk_bit("data drive", wr, data_oe);
    chk_bit("breq", !(gl && sp == EMBI_SP_DATA),
            global_bus_request_n_o);
    chk_bit("fetch", !fe, fetch_indicator_n);
    lat = 0;
    while (core_done !== 1'b1 && lat < 30) begin
      chk_bit("strobe", 1'b0, bus_cycle_strobe_n_o);
      cyc(1);
      lat++;
    end
    chk_bit("done", 1'b1, core_done);
    chk_bit("strobe idle", 1'b1, bus_cycle_strobe_n_o);
    if (wr) chk_word("mem", d, u_embi_ext_model.mem[a[3:0]]);
    else chk_word("rdata", 16'hA500 ^ 16'(a[3:0]), core_rdata);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_spaces();
    for (int i = 0; i < 3; i++) begin
      access(embi_space_t'(i), 1'b1, 1'b0, 1'b0,
             16'h0208 + 16'(i), lat0);
      access(embi_space_t'(i), 1'b0, 1'b0, 1'b0,
             16'h0104 + 16'(i), lat0);
    end
    access(EMBI_SP_PROG, 1'b0, 1'b0, 1'b1, 16'h0003, lat0);
  endtask
  task automatic t_waits();
    wait_cyc = 4'h1;
    access(EMBI_SP_DATA, 1'b0, 1'b0, 1'b0, 16'h0001, lat0);
    wait_cyc = 4'h5;
    access(EMBI_SP_DATA, 1'b0, 1'b0, 1'b0, 16'h0002, lat1);
    chk_word("wait span", 16'h0004, 16'(lat1 - lat0));
    access(EMBI_SP_DATA, 1'b1, 1'b1, 1'b0, 16'h800C, lat0);
    chk_word("grant wait", 16'(lat1), 16'(lat0));
  endtask
  task automatic t_hold();
    hold_req_n = 1'b0;
    n = 0;
    while (bus_hold_grant_n !== 1'b0 && n < 10) begin cyc(1); n++; end
    chk_bit("grant", 1'b0, bus_hold_grant_n);
    chk_bit("hold addr", 1'b0, addr_oe);
    chk_bit("hold data", 1'b0, data_oe);
    chk_bit("hold ctl", 1'b0, ctl_oe);
    chk_bit("hold core", 1'b0, core_ready);
    chk_bit("hold breq", 1'b0, global_bus_request_n_oe);
    u_embi_ext_model.m_br = 1'b0;
    n = 0;
    while (fetch_indicator_n !== 1'b0 && n < 10) begin cyc(1); n++; end
    chk_bit("dma ack", 1'b0, fetch_indicator_n);
    chk_bit("addr input", 1'b0, addr_oe);
    fork
      u_embi_ext_model.dma_access(1'b0, 16'h0123, 16'h7E81);
      begin
        n = 0;
        while (dma_valid !== 1'b1 && n < 12) begin cyc(1); n++; end
        chk_bit("dma valid", 1'b1, dma_valid);
        chk_bit("dma wr", 1'b1, dma_write);
        chk_word("dma addr", 16'h0123, dma_addr);
        chk_word("dma wdata", 16'h7E81, dma_wdata);
      end
    join
    fork
      u_embi_ext_model.dma_access(1'b1, 16'h0124, 16'h0000);
      begin
        n = 0;
        while (data_oe !== 1'b1 && n < 8) begin cyc(1); n++; end
        cyc(1);
        chk_word("dma rdata", 16'hBEEF, data_o);
        chk_bit("dma rd dir", 1'b0, dma_write);
      end
    join
    u_embi_ext_model.m_br = 1'b1;
    hold_req_n = 1'b1;
    cyc(8);
    chk_bit("grant off", 1'b1, bus_hold_grant_n);
    chk_bit("ctl back", 1'b1, ctl_oe);
  endtask
  task automatic t_float();
    emul1_float_all_pin = 1'b0;
    cyc(5);
    chk_bit("off addr", 1'b0, addr_oe);
    chk_bit("off data", 1'b0, data_oe);
    chk_bit("off ctl", 1'b0, ctl_oe);
    chk_bit("off grant", 1'b0, bus_hold_grant_oe);
    chk_bit("off fetch", 1'b0, fetch_indicator_oe);
    emul1_float_all_pin = 1'b1;
    cyc(5);
    chk_bit("on ctl", 1'b1, ctl_oe);
    access(EMBI_SP_IO, 1'b0, 1'b0, 1'b0, 16'h0007, lat0);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    core_valid = 1'b0;
    core_req = '0;
    hold_req_n = 1'b1;
    emul1_float_all_pin = 1'b1;
    wait_cyc = 4'h1;
    dma_rdata = 16'hBEEF;
    cyc(12);
    chk_bit("rst data", 1'b0, data_oe);
    rst_n = 1'b1;
    cyc(4);
    chk_bit("idle rw", 1'b1, rw_o);
    chk_bit("idle dsel", 1'b1, data_space_sel_n);
    chk_bit("idle strobe", 1'b1, bus_cycle_strobe_n_o);
    t_spaces();
    t_waits();
    t_hold();
    t_float();
    close_out();
  end
endmodule
`default_nettype wire
